// >>> common/dsla_defines.vh
// Purpose: Timing counts and widths for the switch latch controller.
// Assumes: 40 MHz system clock, period 25 ns.
// Notes: Counts are derived from the times in ns and rounded up.
`ifndef DSLA_DEFINES_VH
`define DSLA_DEFINES_VH
`define DSLA_CLK_NS 25
`define DSLA_T_ASU_NS 120
`define DSLA_T_WCS_NS 300
`define DSLA_T_WCL_NS 150
`define DSLA_T_DSU_NS 260
`define DSLA_T_HOLD_NS 35
`define DSLA_CYC(ns) (((ns) + `DSLA_CLK_NS - 1) / `DSLA_CLK_NS)
`define DSLA_N_ASU `DSLA_CYC(`DSLA_T_ASU_NS)
`define DSLA_N_WCS `DSLA_CYC(`DSLA_T_WCS_NS)
`define DSLA_N_WCL `DSLA_CYC(`DSLA_T_WCL_NS)
`define DSLA_N_HOLD `DSLA_CYC(`DSLA_T_HOLD_NS)
`define DSLA_CNT_W 5
`define DSLA_NUM_SW 8
`endif

// >>> test/dsla_checker.sv
// Purpose: Pin timing checks on the switch latch controller.
// Assumes: One 25 ns clock, rst_b active low.
// Notes: Figures are whole cycles of 25 ns.
module dsla_checker (
  input logic clk,
  input logic rst_b,
  input logic wr_req,
  input logic [2:0] wr_sel,
  input logic wr_on,
  input logic clr_req,
  input logic req_ready,
  input logic [2:0] sw_addr,
  input logic sw_level,
  input logic strobe_low_one,
  input logic strobe_low_two,
  input logic wipe_all_off,
  input logic [7:0] sw_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_enable_held:
    assert property (!strobe_low_one |-> !strobe_low_two)
      else $error("pulse without enable");
  chk_addr_frozen:
    assert property (!strobe_low_two && $past(!strobe_low_two)
      |-> $stable(sw_addr)) else $error("address moved");
  chk_strobe_width:
    assert property ($fell(strobe_low_one)
      |=> !strobe_low_one[*8] ##1 !strobe_low_one[*3])
      else $error("strobe short");
  chk_clear_width:
    assert property ($rose(wipe_all_off) |=> wipe_all_off[*5])
      else $error("clear short");
  chk_addr_setup:
    assert property ($changed(sw_addr) |-> strobe_low_one[*5])
      else $error("setup short");
  chk_boot_clear:
    assert property ($rose(rst_b) |-> ##[0:3] wipe_all_off)
      else $error("no boot clear");
endmodule
bind dsla_ctrl dsla_checker i_chk (.*);

// >>> test/dsla_latch_model.sv
// Purpose: Behavioural eight-way switch latch array.
// Assumes: No clock; latches open while both strobes are low.
// Notes: Power-up contents are arbitrary until cleared.
module dsla_latch_model (
  input logic [2:0] sw_addr,
  input logic sw_level,
  input logic strobe_low_one,
  input logic strobe_low_two,
  input logic wipe_all_off,
  output logic [7:0] sw
);
  timeunit 1ns;
  timeprecision 1ps;
  // Junk at power-up, so a missing clear shows.
  logic [7:0] latch_q = 8'h5A;
  assign sw = latch_q;
  // Clear wins; else the decoded latch follows the level, others hold.
  always @* begin
    if (wipe_all_off) latch_q = 8'h00;
    else if (!strobe_low_one && !strobe_low_two)
      latch_q[sw_addr] = sw_level;
  end
endmodule

// >>> test/testbench.sv
// Purpose: Self-checking bench for the switch latch controller.
// Assumes: 40 MHz clock, reset held three cycles.
// Notes: The latch model stands in for the switch array.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, wr_req = 1'b0, wr_on = 1'b0;
  logic clr_req = 1'b0;
  logic [2:0] wr_sel = 3'h0;
  logic req_ready, sw_level, strobe_low_one, strobe_low_two, wipe_all_off;
  logic [2:0] sw_addr;
  logic [7:0] sw_state, sw, exp_sw;
  int num_errors = 0, comparisons = 0;
  dsla_ctrl i_dut (.*);
  dsla_latch_model i_model (.*);
  // Free-running 25 ns clock.
  initial forever #12.5 clk = ~clk;
  task stop_test;
    $display("errors %0d compares %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One request; write is raised with clear too, so priority is exercised.
  task go(input logic c, input logic [2:0] s, input logic o);
    while (req_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk);
    wr_req <= 1'b1;
    clr_req <= c;
    wr_sel <= s;
    wr_on <= o;
    @(posedge clk);
    wr_req <= 1'b0;
    clr_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(req_ready, 1'b0)
    while (req_ready !== 1'b1) @(posedge clk) #1;
    `CHK({strobe_low_one, strobe_low_two, wipe_all_off}, 3'h6)
  endtask
  task t_fill;
    for (int i = 0; i < 8; i++) begin
      go(1'b0, i[2:0], 1'b1);
      exp_sw[i] = 1'b1;
      `CHK(sw, exp_sw)
      `CHK(sw_state, exp_sw)
    end
  endtask
  task t_off;
    go(1'b0, 3'h5, 1'b0);
    exp_sw[5] = 1'b0;
    `CHK(sw, exp_sw)
  endtask
  task t_clear;
    go(1'b1, 3'h2, 1'b1);
    `CHK(sw, 8'h00)
    `CHK(sw_state, 8'h00)
  endtask
  task t_boot;
    #1 while (req_ready !== 1'b1) @(posedge clk) #1;
    `CHK(sw, 8'h00)
  endtask
  // Reset, boot clear, then the scenarios.
  initial begin
    repeat (3) @(posedge clk);
    `CHK({strobe_low_one, strobe_low_two, wipe_all_off}, 3'h6)
    `CHK(req_ready, 1'b0)
    rst_b <= 1'b1;
    exp_sw = 8'h00;
    t_boot;
    t_fill;
    t_off;
    t_clear;
    stop_test;
  end
  // Whole run needs about 6 us; a hang is cut off well after.
  initial begin
    #50000;
    num_errors++;
    stop_test;
  end
endmodule

// >>> verilog/dsla_ctrl.v
// Purpose: Host controller driving the decoded switch latch array pins.
// Assumes: Requests are synchronous to clk; the array has no clock.
// Notes: One write or clear at a time; req_ready low while busy.
`include "dsla_defines.vh"
module dsla_ctrl (
  input wire clk,
  input wire rst_b,
  input wire wr_req,
  input wire [2:0] wr_sel,
  input wire wr_on,
  input wire clr_req,
  output wire req_ready,
  output wire [2:0] sw_addr,
  output wire sw_level,
  output wire strobe_low_one,
  output wire strobe_low_two,
  output wire wipe_all_off,
  output wire [`DSLA_NUM_SW-1:0] sw_state
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_STROBE = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_CLEAR = 3'h4;
  localparam ST_GAP = 3'h5;
  // The counts are worked out as integers and cut to the timer width on
  // purpose; every one of them fits in five bits at this clock rate.
  localparam integer N_ASU_I = `DSLA_N_ASU;
  localparam integer N_WCS_I = `DSLA_N_WCS;
  localparam integer N_WCL_I = `DSLA_N_WCL;
  localparam integer N_HOLD_I = `DSLA_N_HOLD;
  localparam [4:0] N_ASU = N_ASU_I[4:0];
  localparam [4:0] N_WCS = N_WCS_I[4:0];
  localparam [4:0] N_WCL = N_WCL_I[4:0];
  localparam [4:0] N_HOLD = N_HOLD_I[4:0];

  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg init_done_r;
  reg t_load;
  reg [4:0] t_val;
  wire t_done;

  // Pin and shadow flip-flops; the output ports are plain copies of them.
  reg [2:0] sw_addr_r;
  reg sw_level_r;
  reg strobe_low_one_r;
  reg strobe_low_two_r;
  reg wipe_all_off_r;
  reg [`DSLA_NUM_SW-1:0] sw_state_r;
  wire [`DSLA_NUM_SW-1:0] sw_state_nxt;
  wire [`DSLA_NUM_SW-1:0] sel_hot;

  // One-cycle markers for the phase boundaries.
  wire take_wr;
  wire take_clr;
  wire setup_end;
  wire pulse_end;
  wire hold_end;
  wire clr_end;

  dsla_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(t_load),
    .load_val(t_val),
    .done(t_done)
  );

  // Accept new work only when idle and after the power-up clear.
  assign req_ready = (st_r == ST_IDLE) && init_done_r;

  // Phase sequencing; each phase but the one-cycle gap is loaded with its minimum duration.
  always @* begin
    st_nxt = st_r;
    t_load = 1'b0;
    t_val = 5'h00;
    case (st_r)
      ST_IDLE: begin
        if (!init_done_r || clr_req) begin
          st_nxt = ST_CLEAR;
          t_load = 1'b1;
          t_val = N_WCL;
        end else if (wr_req) begin
          st_nxt = ST_SETUP;
          t_load = 1'b1;
          t_val = N_ASU;
        end
      end
      ST_SETUP: begin
        if (t_done) begin
          st_nxt = ST_STROBE;
          t_load = 1'b1;
          t_val = N_WCS;
        end
      end
      ST_STROBE: begin
        if (t_done) begin
          st_nxt = ST_HOLD;
          t_load = 1'b1;
          t_val = N_HOLD;
        end
      end
      ST_HOLD: begin
        if (t_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_CLEAR: begin
        if (t_done) begin
          st_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Phase boundaries, decoded once so each pin driver below stays small.
  assign take_wr = (st_r == ST_IDLE) && (st_nxt == ST_SETUP);
  assign take_clr = (st_r == ST_IDLE) && (st_nxt == ST_CLEAR);
  assign setup_end = (st_r == ST_SETUP) && (st_nxt == ST_STROBE);
  assign pulse_end = (st_r == ST_STROBE) && (st_nxt == ST_HOLD);
  assign hold_end = (st_r == ST_HOLD) && (st_nxt == ST_IDLE);
  assign clr_end = (st_r == ST_CLEAR) && (st_nxt == ST_GAP);

  // State register and the flag that records the power-up clear.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      init_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (clr_end) begin
        init_done_r <= 1'b1;
      end
    end
  end

  // Address and level move only when a write is taken, while the pulse
  // strobe is still high, so no latch can open on a half-changed address.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_addr_r <= 3'h0;
      sw_level_r <= 1'b0;
    end else if (take_wr) begin
      sw_addr_r <= wr_sel;
      sw_level_r <= wr_on;
    end
  end

  // Enable strobe: low from the address set-up until the hold time after
  // the pulse has passed, so the pulse strobe alone frames the write.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_low_two_r <= 1'b1;
    end else if (take_wr) begin
      strobe_low_two_r <= 1'b0;
    end else if (hold_end) begin
      strobe_low_two_r <= 1'b1;
    end
  end

  // Pulse strobe: falls once the decode has settled and rises after the
  // minimum low width, both lengths set by the timer.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_low_one_r <= 1'b1;
    end else if (setup_end) begin
      strobe_low_one_r <= 1'b0;
    end else if (pulse_end) begin
      strobe_low_one_r <= 1'b1;
    end
  end

  // Clear pin: high for the whole clear phase, which the timer sizes.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wipe_all_off_r <= 1'b0;
    end else if (take_clr) begin
      wipe_all_off_r <= 1'b1;
    end else if (clr_end) begin
      wipe_all_off_r <= 1'b0;
    end
  end

  // One-hot decode of the address pins, the same selection the array makes.
  assign sel_hot = 8'h01 << sw_addr_r;

  // Next shadow value per switch: only the selected bit takes the level
  // when its pulse ends; every other bit keeps what it had.
  genvar gi;
  generate
    for (gi = 0; gi < `DSLA_NUM_SW; gi = gi + 1) begin : g_shadow
      assign sw_state_nxt[gi] = (pulse_end && sel_hot[gi]) ? sw_level_r :
                                sw_state_r[gi];
    end
  endgenerate

  // Shadow of the switch states.  It is only as true as the array's own
  // latches, which the controller cannot read back.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_state_r <= 8'h00;
    end else if (clr_end) begin
      sw_state_r <= 8'h00;
    end else begin
      sw_state_r <= sw_state_nxt;
    end
  end

  // Pins and shadow come straight from flip-flops.
  assign sw_addr = sw_addr_r;
  assign sw_level = sw_level_r;
  assign strobe_low_one = strobe_low_one_r;
  assign strobe_low_two = strobe_low_two_r;
  assign wipe_all_off = wipe_all_off_r;
  assign sw_state = sw_state_r;
endmodule

// >>> verilog/dsla_timer.v
// Purpose: Down-counter that flags when a programmed delay has expired.
// Assumes: load and count never arrive together with a busy reload.
// Notes: done is high when the count has reached zero.
`include "dsla_defines.vh"
module dsla_timer (
  input wire clk,
  input wire rst_b,
  input wire load,
  input wire [`DSLA_CNT_W-1:0] load_val,
  output wire done
);
  reg [`DSLA_CNT_W-1:0] cnt_r;

  // Load wins over counting so a new phase always gets its full time.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 5'h00;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  assign done = (cnt_r == 5'h00);
endmodule
